// ===== bench/trts_far_end.sv
/*
  Far-side model: user logic clocks, reconfiguration controller and test pattern source.
  Assumes it shares the system clock, from which its slower clocks are divided.
*/
`timescale 1ns/10ps
module trts_far_end (
  // Clock and stream control
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic flip_i,
  // Flags from the block
  input wire logic done_i,
  input wire logic error_i,
  // Clocks, command bus and stream
  output logic reconfiguration_clock_o,
  output logic calibration_clock_o,
  output logic [trts_pkg::RCFG_W-1:0] reconfig_command_o,
  output logic test_bit_o = 1'h0,
  output logic test_valid_o = 1'h0,
  // Flags in this clock domain
  output logic done_sync_o,
  output logic error_sync_o
);
  import trts_pkg::*;
  logic [6:0] lfsr = 7'h7f;
  logic [2:0] div = 3'h0;
  logic [1:0] ds = 2'h0;
  logic [1:0] es = 2'h0;
  wire nb = lfsr[6] ^ lfsr[5];
  assign reconfiguration_clock_o = div[2];
  assign calibration_clock_o = div[1];
  assign reconfig_command_o = 16'hc3a5;
  assign done_sync_o = ds[1];
  assign error_sync_o = es[1];
  always @(posedge clk_i) begin
    div <= div + 3'h1;
    test_valid_o <= run_i;
    ds <= {ds[0], done_i};
    es <= {es[0], error_i};
    if (run_i) begin
      lfsr <= {lfsr[5:0], nb};
      test_bit_o <= nb ^ flip_i;
    end else begin
      // An idle line must not look like a held bit.
      test_bit_o <= ~test_bit_o;
    end
  end
endmodule

// ===== bench/trts_reset_status_chk.sv
/*
  Port-level checker for the transceiver reset, power-down and test-status block.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/10ps
module trts_reset_status_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Pins
  input wire logic block_power_down_i,
  input wire logic tx_coding_reset_i,
  input wire logic rx_analog_front_reset_i,
  input wire logic rx_coding_reset_i,
  input wire logic calibration_power_down_i,
  // Watched outputs
  input wire logic coding_power_en_o,
  input wire logic hsi_power_en_o,
  input wire logic cdr_power_en_o,
  input wire logic pcie_power_en_o,
  input wire logic refclk_buf_en_o,
  input wire logic tx_coding_rst_o,
  input wire logic rx_analog_rst_o,
  input wire logic rx_coding_rst_o,
  input wire logic cal_power_down_o,
  input wire logic cal_tick_o,
  input wire logic verifier_done_o,
  input wire logic verifier_error_o
);
  // ====================
  // Settling window
  // A pin needs three enabled edges to reach an output, so the pin checks wait
  // for four enabled edges free of reset.
  logic [3:0] run_q;
  wire ok = &run_q;
  always_ff @(posedge clk_i) begin
    run_q <= {run_q[2:0], ce_i & ~sys_rst_i};
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ====================
  // Assertions
  a_refclk_on:
    assert property (refclk_buf_en_o) else $error("reference clock buffer off");
  a_pd_domains_off:
    assert property (ok && $past(block_power_down_i, 3) |-> !coding_power_en_o &&
      !hsi_power_en_o && !cdr_power_en_o && !pcie_power_en_o)
    else $error("domain powered during power-down");
  a_pd_holds_resets:
    assert property (ok && $past(block_power_down_i, 3) |-> tx_coding_rst_o &&
      rx_analog_rst_o && rx_coding_rst_o && cal_power_down_o)
    else $error("reset released during power-down");
  a_tx_rst_follow:
    assert property (ok && $past(tx_coding_reset_i, 3) |-> tx_coding_rst_o)
    else $error("transmit coding reset not applied");
  a_rxa_rst_follow:
    assert property (ok && $past(rx_analog_front_reset_i, 3) |-> rx_analog_rst_o)
    else $error("receive analog reset not applied");
  a_rx_rst_follow:
    assert property (ok && $past(rx_coding_reset_i, 3) |-> rx_coding_rst_o)
    else $error("receive coding reset not applied");
  a_cal_pd_follow:
    assert property (ok && $past(calibration_power_down_i, 3) |-> cal_power_down_o)
    else $error("calibration not powered down");
  a_cal_tick_off:
    assert property (ok && cal_power_down_o && $past(cal_power_down_o) |-> !cal_tick_o)
    else $error("calibration tick while powered down");
  a_rst_clears_flags:
    assert property (ok && $past(rx_coding_rst_o, 2) |-> !verifier_done_o && !verifier_error_o)
    else $error("verifier flags survive coding reset");
  a_done_sticky:
    assert property (ok && $fell(verifier_done_o) |->
      $past(rx_coding_rst_o) || $past(rx_coding_rst_o, 2))
    else $error("done fell without coding reset");
  a_err_hold_three:
    assert property (ok && $rose(verifier_error_o) && !rx_coding_rst_o |=>
      (verifier_error_o || rx_coding_rst_o) [*2])
    else $error("error flag shorter than three cycles");
  c_done: cover property ($rose(verifier_done_o));
  c_error: cover property ($rose(verifier_error_o));
  c_power_down: cover property (ok && $past(block_power_down_i, 3));
endmodule
bind trts_reset_status trts_reset_status_chk trts_reset_status_chk_inst (.clk_i, .sys_rst_i,
  .ce_i, .block_power_down_i, .tx_coding_reset_i, .rx_analog_front_reset_i, .rx_coding_reset_i,
  .calibration_power_down_i, .coding_power_en_o, .hsi_power_en_o, .cdr_power_en_o,
  .pcie_power_en_o, .refclk_buf_en_o, .tx_coding_rst_o, .rx_analog_rst_o, .rx_coding_rst_o,
  .cal_power_down_o, .cal_tick_o, .verifier_done_o, .verifier_error_o);

// ===== bench/trts_reset_status_tb.sv
/*
  Self-checking bench for the transceiver reset, power-down and test-status block.
  Assumes the far-side model supplies the slow clocks, command bus and test stream.
*/
`timescale 1ns/10ps
module trts_reset_status_tb;
  import trts_pkg::*;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic [ADDR_W-1:0] paddr_i = 12'h000;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [DATA_W-1:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [STRB_W-1:0] pstrb_i = 4'h0;
  logic pready_o, pslverr_o, er, run = 1'h0, flip = 1'h0, done_s, err_s;
  logic [4:0] pins = 5'h00;
  wire block_power_down_i = pins[4];
  wire tx_coding_reset_i = pins[3];
  wire rx_analog_front_reset_i = pins[2];
  wire rx_coding_reset_i = pins[1];
  wire calibration_power_down_i = pins[0];
  logic reconfiguration_clock_i, calibration_clock_i, rx_test_bit_i, rx_test_valid_i;
  logic [RCFG_W-1:0] reconfig_command_in_i, reconfig_status_out_o;
  logic coding_power_en_o, hsi_power_en_o, cdr_power_en_o, pcie_power_en_o, refclk_buf_en_o;
  logic tx_coding_rst_o, rx_analog_rst_o, rx_coding_rst_o, cal_power_down_o;
  logic cal_tick_o, reconfig_tick_o, offset_cancel_tick_o, verifier_done_o, verifier_error_o;
  wire [7:0] outs = {coding_power_en_o, hsi_power_en_o, cdr_power_en_o, pcie_power_en_o,
    tx_coding_rst_o, rx_analog_rst_o, rx_coding_rst_o, cal_power_down_o};
  int miscompares = 0, compares = 0, cycles = 0, n_rc = 0, n_oc = 0, n_cal = 0;
  logic [4:0] row_pin [6] = '{5'h00, 5'h08, 5'h04, 5'h02, 5'h01, 5'h10};
  logic [7:0] row_exp [6] = '{8'hf0, 8'hf8, 8'hf4, 8'hf2, 8'hf1, 8'h0f};
  trts_reset_status trts_reset_status_inst (.clk_i, .sys_rst_i, .ce_i, .paddr_i, .psel_i,
    .penable_i, .pwrite_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .block_power_down_i, .tx_coding_reset_i, .rx_analog_front_reset_i, .rx_coding_reset_i,
    .calibration_power_down_i, .reconfiguration_clock_i, .calibration_clock_i,
    .reconfig_command_in_i, .reconfig_status_out_o, .rx_test_bit_i, .rx_test_valid_i,
    .coding_power_en_o, .hsi_power_en_o, .cdr_power_en_o, .pcie_power_en_o, .refclk_buf_en_o,
    .tx_coding_rst_o, .rx_analog_rst_o, .rx_coding_rst_o, .cal_power_down_o, .cal_tick_o,
    .reconfig_tick_o, .offset_cancel_tick_o, .verifier_done_o, .verifier_error_o);
  trts_far_end trts_far_end_inst (.clk_i, .run_i(run), .flip_i(flip), .done_i(verifier_done_o),
    .error_i(verifier_error_o), .reconfiguration_clock_o(reconfiguration_clock_i),
    .calibration_clock_o(calibration_clock_i), .reconfig_command_o(reconfig_command_in_i),
    .test_bit_o(rx_test_bit_i), .test_valid_o(rx_test_valid_i), .done_sync_o(done_s),
    .error_sync_o(err_s));
  always #4 clk_i = ~clk_i;
  // ====================
  // Helpers
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [DATA_W-1:0] e,
                          input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Ticks stand one cycle, so each is seen exactly once at an edge.
  always @(posedge clk_i) begin
    cycles++;
    n_rc += reconfig_tick_o;
    n_oc += offset_cancel_tick_o;
    n_cal += cal_tick_o;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [STRB_W-1:0] s);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1) begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rdw(input logic [ADDR_W-1:0] a);
    apb(1'h0, a, 32'h0, 4'h0);
  endtask
  task automatic wrw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'h1, a, d, 4'hf);
  endtask
  task automatic stream(input int n, input logic f);
    flip <= f;
    run <= 1'h1;
    cyc(1);
    flip <= 1'h0;
    cyc(n - 1);
    run <= 1'h0;
    cyc(8);
  endtask
  // ====================
  // Tests
  initial begin
    cyc(10);
    sys_rst_i <= 1'h0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      pins <= row_pin[i];
      cyc(4);
      chk_word("outs", {24'h0, row_exp[i]}, {24'h0, outs});
      chk_bit("refclk", 1'h1, refclk_buf_en_o);
      rdw(STATUS_OFS);
      chk_word("status", {25'h0, row_pin[i][0], row_exp[i][1], row_exp[i][2], row_exp[i][3],
        ~row_exp[i][7], 2'h0}, rd);
    end
    pins <= 5'h00;
    cyc(4);
    $display("test pin rows done");
    apb(1'h1, CTRL_OFS, 32'h0000ff01, 4'h1);
    rdw(CTRL_OFS);
    chk_word("ctrl strobe", 32'h1, rd);
    chk_word("ctrl power-down", 32'h0f, {24'h0, outs});
    wrw(CTRL_OFS, 32'h0);
    rdw(12'h010);
    chk_bit("slverr", 1'h1, er);
    chk_word("unmapped", 32'h0, rd);
    wrw(STATUS_OFS, 32'hffffffff);
    rdw(STATUS_OFS);
    chk_word("status ro", 32'h0, rd);
    wrw(RCFG_STAT_OFS, 32'h1234abcd);
    rdw(RCFG_STAT_OFS);
    chk_word("rcfg stat", 32'habcd, rd);
    chk_word("status out", 32'habcd, {16'h0, reconfig_status_out_o});
    rdw(RCFG_CMD_OFS);
    chk_word("rcfg cmd", 32'hc3a5, rd);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      wrw(CTRL_OFS, m ? 32'h40 : 32'h0);
      pins <= m ? 5'h01 : 5'h00;
      cyc(10);
      n_rc = 0;
      n_oc = 0;
      n_cal = 0;
      cyc(200);
      chk_bit("reconfig ticks", 1'h1, n_rc != 0);
      chk_bit("offset ticks", !m, n_oc != 0);
      chk_bit("cal ticks", !m, n_cal != 0);
    end
    pins <= 5'h00;
    wrw(CTRL_OFS, 32'h80);
    $display("test clocks done");
    stream(20, 1'h1);
    chk_bit("bist done on error", 1'h1, done_s);
    chk_bit("bist error", 1'h1, err_s);
    stream(300, 1'h0);
    chk_bit("bist error sticky", 1'h1, err_s);
    pins <= 5'h02;
    cyc(4);
    pins <= 5'h00;
    cyc(6);
    chk_bit("done cleared", 1'h0, done_s);
    chk_bit("error cleared", 1'h0, err_s);
    wrw(CTRL_OFS, 32'ha0);
    stream(133, 1'h0);
    chk_bit("prbs done early", 1'h0, done_s);
    stream(1, 1'h0);
    chk_bit("prbs done", 1'h1, done_s);
    stream(9, 1'h1);
    chk_bit("prbs error", 1'h1, err_s);
    stream(300, 1'h0);
    chk_bit("prbs error clear", 1'h0, err_s);
    chk_bit("prbs done kept", 1'h1, done_s);
    $display("test verifier done");
    ce_i <= 1'h0;
    pins <= 5'h10;
    cyc(6);
    chk_word("frozen outs", 32'hf0, {24'h0, outs});
    ce_i <= 1'h1;
    cyc(4);
    chk_word("thawed outs", 32'h0f, {24'h0, outs});
    pins <= 5'h00;
    cyc(4);
    $display("test enable done");
    wrw(CTRL_OFS, 32'h01);
    sys_rst_i <= 1'h1;
    cyc(2);
    chk_word("reset outs", 32'h0f, {24'h0, outs});
    chk_word("reset flags", 32'h0, {14'h0, reconfig_status_out_o, verifier_done_o,
      verifier_error_o});
    sys_rst_i <= 1'h0;
    cyc(4);
    chk_word("release outs", 32'hf0, {24'h0, outs});
    rdw(CTRL_OFS);
    chk_word("ctrl reset", {24'h0, CTRL_RST}, rd);
    $display("test reset done");
    complete_run();
  end
endmodule

// ===== design/trts_reset_status.sv
/*
  Transceiver block reset, power-down, calibration, reconfiguration and
  test-status control with an APB register slave.
  Assumes the pin inputs are asynchronous to clk_i and that the receive
  test bit stream comes from logic on clk_i.

  // Summary of operation
  // R1 - Power-down disables every transceiver circuit domain.
  // R2 - Reference clock buffers stay on always.
  // R3 - Resets held at least two cycles.
  // R4 - Transmit coding reset holds transmit logic.
  // R5 - Receive analog reset resets analog front.
  // R6 - Receive coding reset holds receive logic.
  // R7 - Reconfig clock drives reconfiguration, offset cancellation.
  // R8 - Reconfig command in, status out, asynchronous.
  // R9 - Calibration clocked, powered down by input.
  // R10 - BIST done on full cycle or error.
  // R11 - PRBS done on full cycle, sticky.
  // R12 - BIST error sticky until coding reset.
  // R13 - PRBS error holds three cycles, clean clears.
  // R14 - Far side synchronises done and error.
*/
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module trts_reset_status (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic [trts_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [trts_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [trts_pkg::STRB_W-1:0] pstrb_i,
  output logic [trts_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Asynchronous control pins
  input wire logic block_power_down_i,
  input wire logic tx_coding_reset_i,
  input wire logic rx_analog_front_reset_i,
  input wire logic rx_coding_reset_i,
  input wire logic calibration_power_down_i,
  input wire logic reconfiguration_clock_i,
  input wire logic calibration_clock_i,
  // Reconfiguration controller buses
  input wire logic [trts_pkg::RCFG_W-1:0] reconfig_command_in_i,
  output logic [trts_pkg::RCFG_W-1:0] reconfig_status_out_o,
  // Receive test stream
  input wire logic rx_test_bit_i,
  input wire logic rx_test_valid_i,
  // Circuit domain controls
  output logic coding_power_en_o,
  output logic hsi_power_en_o,
  output logic cdr_power_en_o,
  output logic pcie_power_en_o,
  output logic refclk_buf_en_o,
  output logic tx_coding_rst_o,
  output logic rx_analog_rst_o,
  output logic rx_coding_rst_o,
  output logic cal_power_down_o,
  output logic cal_tick_o,
  output logic reconfig_tick_o,
  output logic offset_cancel_tick_o,
  // Test status
  output logic verifier_done_o,
  output logic verifier_error_o
);
  import trts_pkg::*;

  // ==========================================================================
  // Pin synchronisers

  // The two-cycle minimum pulse on the reset pins is what lets a
  // two-stage synchroniser catch them without a pulse stretcher.
  wire logic [SYNC_W-1:0] pins_raw = {reconfig_command_in_i, calibration_clock_i,
    reconfiguration_clock_i, calibration_power_down_i, rx_coding_reset_i,
    rx_analog_front_reset_i, tx_coding_reset_i, block_power_down_i}; // see R3 R8
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
    end
  end

  wire logic pd_pin = sync_reg[0];
  wire logic txr_pin = sync_reg[1];
  wire logic rxa_pin = sync_reg[2];
  wire logic rxr_pin = sync_reg[3];
  wire logic calpd_pin = sync_reg[4];
  wire logic rcfg_clk_s = sync_reg[5];
  wire logic cal_clk_s = sync_reg[6];
  wire logic [RCFG_W-1:0] rcfg_cmd_s = sync_reg[PIN_N +: RCFG_W];

  // ==========================================================================
  // APB register file

  logic [CTRL_W-1:0] ctrl_reg;
  logic [RCFG_W-1:0] rcfg_stat_reg;
  logic [RCFG_W-1:0] rcfg_cmd_reg;
  logic [DATA_W-1:0] rdata_reg;

  wire logic sel_ctrl = (paddr_i == CTRL_OFS);
  wire logic sel_status = (paddr_i == STATUS_OFS);
  wire logic sel_cmd = (paddr_i == RCFG_CMD_OFS);
  wire logic sel_stat = (paddr_i == RCFG_STAT_OFS);
  wire logic addr_ok = sel_ctrl || sel_status || sel_cmd || sel_stat;
  wire logic setup = psel_i && !penable_i;
  wire logic wr_acc = psel_i && penable_i && pwrite_i && addr_ok;

  wire logic [DATA_W-1:0] ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
  wire logic [DATA_W-1:0] stat_word = {{(DATA_W-RCFG_W){1'b0}}, rcfg_stat_reg};
  wire logic [DATA_W-1:0] ctrl_merged = trts_merge(ctrl_word, pwdata_i, pstrb_i);
  wire logic [DATA_W-1:0] stat_merged = trts_merge(stat_word, pwdata_i, pstrb_i);

  // ==========================================================================
  // Effective controls: pin or software, power-down overrides the three resets

  wire logic pd_eff = pd_pin || ctrl_reg[CTRL_PD];
  wire logic txr_eff = txr_pin || ctrl_reg[CTRL_TX_RST] || pd_eff;
  wire logic rxa_eff = rxa_pin || ctrl_reg[CTRL_RXA_RST] || pd_eff;
  wire logic rxr_eff = rxr_pin || ctrl_reg[CTRL_RX_RST] || pd_eff;
  wire logic calpd_eff = calpd_pin || ctrl_reg[CTRL_CAL_PD];
  wire logic pipe_mode = ctrl_reg[CTRL_PIPE];

  logic rcfg_clk_d_reg;
  logic cal_clk_d_reg;
  wire logic rcfg_rise = rcfg_clk_s && !rcfg_clk_d_reg;
  wire logic cal_rise = cal_clk_s && !cal_clk_d_reg;

  logic [ST_W-1:0] status_v;
  trts_vrf_if vif ();

  assign status_v[ST_DONE] = vif.done;
  assign status_v[ST_ERR] = vif.error;
  assign status_v[ST_PD] = pd_eff;
  assign status_v[ST_TX_RST] = txr_eff;
  assign status_v[ST_RXA_RST] = rxa_eff;
  assign status_v[ST_RX_RST] = rxr_eff;
  assign status_v[ST_CAL_PD] = calpd_eff;

  logic [DATA_W-1:0] rd_mux;
  assign rd_mux = sel_ctrl ? ctrl_word :
                  sel_status ? {{(DATA_W-ST_W){1'b0}}, status_v} :
                  sel_cmd ? {{(DATA_W-RCFG_W){1'b0}}, rcfg_cmd_reg} :
                  sel_stat ? stat_word : '0;

  // Read data is captured in the setup cycle so the access phase needs
  // no wait states and prdata still comes from a flip-flop.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST;
      rcfg_stat_reg <= RCFG_RST;
      rdata_reg <= '0;
    end else if (ce_i) begin
      if (setup) begin
        rdata_reg <= rd_mux;
      end
      if (wr_acc && sel_ctrl) begin
        ctrl_reg <= ctrl_merged[CTRL_W-1:0];
      end
      if (wr_acc && sel_stat) begin
        rcfg_stat_reg <= stat_merged[RCFG_W-1:0];
      end
    end
  end

  // With the clock enable low the slave stalls rather than answering,
  // so no transfer completes while the register state is frozen.
  assign pready_o = ce_i;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign prdata_o = rdata_reg;

  // ==========================================================================
  // Reconfiguration and calibration clock edges

  // The command bus is caught on a rising reconfiguration clock edge,
  // after it has settled through the synchroniser; the controller must
  // keep it stable across that edge since bits are not skew protected.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rcfg_clk_d_reg <= 1'b0;
      cal_clk_d_reg <= 1'b0;
      rcfg_cmd_reg <= RCFG_RST;
    end else if (ce_i) begin
      rcfg_clk_d_reg <= rcfg_clk_s;
      cal_clk_d_reg <= cal_clk_s;
      if (rcfg_rise) begin
        rcfg_cmd_reg <= rcfg_cmd_s; // see R7 R8
      end
    end
  end

  // ==========================================================================
  // Registered outputs

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      coding_power_en_o <= 1'b0;
      hsi_power_en_o <= 1'b0;
      cdr_power_en_o <= 1'b0;
      pcie_power_en_o <= 1'b0;
      refclk_buf_en_o <= 1'b1;
      tx_coding_rst_o <= 1'b1;
      rx_analog_rst_o <= 1'b1;
      rx_coding_rst_o <= 1'b1;
      cal_power_down_o <= 1'b1;
      cal_tick_o <= 1'b0;
      reconfig_tick_o <= 1'b0;
      offset_cancel_tick_o <= 1'b0;
      reconfig_status_out_o <= RCFG_RST;
      verifier_done_o <= 1'b0;
      verifier_error_o <= 1'b0;
    end else if (ce_i) begin
      coding_power_en_o <= !pd_eff; // see R1
      hsi_power_en_o <= !pd_eff; // see R1
      cdr_power_en_o <= !pd_eff; // see R1
      pcie_power_en_o <= !pd_eff; // see R1
      refclk_buf_en_o <= 1'b1; // see R2
      tx_coding_rst_o <= txr_eff; // see R4
      rx_analog_rst_o <= rxa_eff; // see R5
      rx_coding_rst_o <= rxr_eff; // see R6
      cal_power_down_o <= calpd_eff || pd_eff; // see R9
      cal_tick_o <= cal_rise && !calpd_eff && !pd_eff; // see R9
      reconfig_tick_o <= rcfg_rise; // see R7
      offset_cancel_tick_o <= rcfg_rise && !pipe_mode && !pd_eff; // see R7
      reconfig_status_out_o <= rcfg_stat_reg; // see R8
      verifier_done_o <= vif.done;
      verifier_error_o <= vif.error;
    end
  end

  // ==========================================================================
  // Pattern verifier

  assign vif.clear = rxr_eff; // see R6 R10 R12
  assign vif.enable = ctrl_reg[CTRL_VRF_EN];
  assign vif.prbs_mode = ctrl_reg[CTRL_PRBS];
  assign vif.bit_in = rx_test_bit_i;
  assign vif.bit_valid = rx_test_valid_i;

  trts_verifier u_verifier (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .vrf(vif)
  );

endmodule

// ===== design/trts_verifier.sv
/*
  Self-synchronising pattern verifier with BIST and PRBS flag behaviour.
  Assumes the received bit stream arrives on the system clock with a valid.
*/
`timescale 1ns/10ps
module trts_verifier (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Verifier carrier
  trts_vrf_if.vrf vrf
);
  import trts_pkg::*;

  logic [PAT_ORD-1:0] shift_reg, shift_next;
  logic [2:0] fill_reg, fill_next;
  logic [6:0] seq_reg, seq_next;
  logic seq_err_reg, seq_err_next;
  logic [1:0] hold_reg, hold_next;
  logic done_reg, done_next;
  logic err_reg, err_next;

  wire logic take = vrf.enable && vrf.bit_valid;
  wire logic checking = (fill_reg == PAT_FILL);
  wire logic expect_bit = shift_reg[PAT_TAP] ^ shift_reg[PAT_TAP-1];
  wire logic mismatch = take && checking && (vrf.bit_in != expect_bit);
  wire logic seq_end = take && checking && (seq_reg == PAT_LEN_M1);
  wire logic clean_seq = seq_end && !seq_err_reg && !mismatch;

  always_comb begin
    shift_next = take ? {shift_reg[PAT_ORD-2:0], vrf.bit_in} : shift_reg;
    fill_next = (take && !checking) ? fill_reg + 3'h1 : fill_reg;
    seq_next = seq_end ? 7'h00 : ((take && checking) ? seq_reg + 7'h01 : seq_reg);
    seq_err_next = seq_end ? 1'b0 : (seq_err_reg || mismatch);
    hold_next = (hold_reg != 2'h0) ? hold_reg - 2'h1 : hold_reg;
    done_next = done_reg;
    err_next = err_reg;
    if (!vrf.prbs_mode) begin
      // BIST: done on a full cycle or on the first error, both sticky.
      done_next = done_reg || seq_end || mismatch; // see R10
      err_next = err_reg || mismatch; // see R12
    end else begin
      done_next = done_reg || seq_end; // see R11
      if (mismatch) begin
        err_next = 1'b1; // see R13
        hold_next = ERR_HOLD_M1;
      end else if (clean_seq && hold_reg == 2'h0) begin
        err_next = 1'b0; // see R13
      end
    end
  end

  // The coding reset, set directly or forced by power-down, is the only way software can drop sticky flags.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (ce_i && vrf.clear)) begin
      shift_reg <= '0;
      fill_reg <= 3'h0;
      seq_reg <= 7'h00;
      seq_err_reg <= 1'b0;
      hold_reg <= 2'h0;
      done_reg <= 1'b0; // see R10 R11
      err_reg <= 1'b0; // see R12
    end else if (ce_i) begin
      shift_reg <= shift_next;
      fill_reg <= fill_next;
      seq_reg <= seq_next;
      seq_err_reg <= seq_err_next;
      hold_reg <= hold_next;
      done_reg <= done_next;
      err_reg <= err_next;
    end
  end

  assign vrf.done = done_reg;
  assign vrf.error = err_reg;
endmodule

// ===== pkg/trts_pkg.sv
/*
  Constants shared by the transceiver reset, power-down and test-status block:
  register offsets, bit positions, reset values and verifier timing.
  Assumes a 32-bit APB slave with 12 address bits and byte write strobes.
*/
package trts_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] RCFG_CMD_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] RCFG_STAT_OFS = 12'h00c;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTRL_PD = 0;
  localparam int unsigned CTRL_TX_RST = 1;
  localparam int unsigned CTRL_RXA_RST = 2;
  localparam int unsigned CTRL_RX_RST = 3;
  localparam int unsigned CTRL_CAL_PD = 4;
  localparam int unsigned CTRL_PRBS = 5;
  localparam int unsigned CTRL_PIPE = 6;
  localparam int unsigned CTRL_VRF_EN = 7;
  localparam int unsigned CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // ==========================================================================
  // Status register fields
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_ERR = 1;
  localparam int unsigned ST_PD = 2;
  localparam int unsigned ST_TX_RST = 3;
  localparam int unsigned ST_RXA_RST = 4;
  localparam int unsigned ST_RX_RST = 5;
  localparam int unsigned ST_CAL_PD = 6;
  localparam int unsigned ST_W = 7;

  // ==========================================================================
  // Reconfiguration buses and pin synchroniser
  localparam int unsigned RCFG_W = 16;
  localparam logic [RCFG_W-1:0] RCFG_RST = 16'h0000;
  localparam int unsigned PIN_N = 7;
  localparam int unsigned SYNC_W = PIN_N + RCFG_W;

  // ==========================================================================
  // Verifier: 7-bit pattern, 127 bits per cycle, error held 3 cycles minimum
  localparam int unsigned PAT_ORD = 7;
  localparam int unsigned PAT_TAP = 6;
  localparam logic [6:0] PAT_LEN_M1 = 7'h7e;
  localparam logic [2:0] PAT_FILL = 3'h7;
  localparam logic [1:0] ERR_HOLD_M1 = 2'h2;

  // Merges write data into a register under the APB byte strobes.
  function automatic logic [DATA_W-1:0] trts_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ===== pkg/trts_vrf_if.sv
/*
  Carrier between the control block and its pattern verifier.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface trts_vrf_if;
  logic clear;
  logic enable;
  logic prbs_mode;
  logic bit_in;
  logic bit_valid;
  logic done;
  logic error;

  modport ctl (output clear, output enable, output prbs_mode, output bit_in,
               output bit_valid, input done, input error);
  modport vrf (input clear, input enable, input prbs_mode, input bit_in,
               input bit_valid, output done, output error);
endinterface
